// file: mdc_pkg.sv
/*
  mdc_pkg: constants, encodings and timing figures of the meter display controller.
  assumes a 40 MHz clk; all long intervals are counted in whole seconds.
*/
// Function
// RULE1: with lighting configured, backlight goes off 15 s after the latest key press
// RULE2: per mode code, display blanks 4 min after last key or stays on
// RULE3: one mode code keeps the backlight permanently lit
// RULE4: readings shown on 7 or 8 digits as configured, with symbols
// RULE5: a key wakes a blank display, otherwise advances or changes the reading
// RULE6: four reading sequences: consumer, service, configuration, reverification
// RULE7: first flow of at least 1 % nominal blocks configuration until seal broken
// RULE8: reverification sequence only while the verification seal is broken
// RULE9: transport state opens consumer, service, configuration; country setting may block configuration
// RULE10: primary key held 5 s opens the chooser; arrows step sequences
// RULE11: service, configuration, reverification show index numbers; consumer shows none
// RULE12: open or shorted sensor dashes affected readings and raises an info code
// RULE13: a sensor error halts every accumulator depending on the failed quantity
// RULE14: inlet or outlet fault dashes difference and power; volume keeps counting
// RULE15: flow reading forced to zero after 60 min without a flow pulse
// RULE16: heartbeat segment flashes while both metering core and display are active
// RULE17: config segment steady when log full, flashing while accessible, else off
// RULE18: optical segment steady disabled, off enabled, flashing 4 min after separation
// RULE19: energies always positive; difference and power negative when cooling
// RULE20: OK symbol shown after a changed value has been stored
// RULE21: info symbol flashes while any info code is active
// RULE22: in service sequence arrows step readings, short primary press toggles secondaries
// RULE23: all intervals counted from one second tick; key activity restarts display timers
package mdc_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_NS = 1000000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int BACKLIGHT_S = 15;
  localparam int DISPLAY_OFF_MIN = 4;
  localparam int DISPLAY_OFF_S = DISPLAY_OFF_MIN * 60;
  localparam int PRIMARY_HOLD_S = 5;
  localparam int FLOW_TIMEOUT_MIN = 60;
  localparam int FLOW_TIMEOUT_S = FLOW_TIMEOUT_MIN * 60;
  localparam int SEP_WINDOW_MIN = 4;
  localparam int SEP_WINDOW_S = SEP_WINDOW_MIN * 60;
  localparam logic [23:0] FIRST_FLOW_PCT = 24'h000001;
  localparam logic [23:0] PCT_SCALE = 24'h000064;
  localparam logic [3:0] DIGITS_SHORT = 4'h7;
  localparam logic [3:0] DIGITS_LONG = 4'h8;
  localparam int READINGS_DEF = 32;
  localparam int SUBS_DEF = 8;
  localparam int ACC_COUNT = 11;
  // accumulator halt masks, bit n is accumulator n+1
  localparam logic [10:0] HALT_INLET = 11'h0cf;
  localparam logic [10:0] HALT_OUTLET = 11'h117;
  localparam logic [10:0] HALT_THIRD = 11'h678;
  localparam logic [1:0] MODE_TIMED = 2'h0;
  localparam logic [1:0] MODE_DISP_ON = 2'h1;
  localparam logic [1:0] MODE_LIGHT_ON = 2'h2;
  typedef enum logic [1:0] {
    MDC_SEQ_CONSUMER = 2'h0,
    MDC_SEQ_SERVICE = 2'h1,
    MDC_SEQ_CONFIG = 2'h2,
    MDC_SEQ_REVERIFY = 2'h3
  } mdc_seq_t;
  typedef enum logic {
    MDC_UI_RUN = 1'h0,
    MDC_UI_CHOOSE = 1'h1
  } mdc_ui_t;
  localparam mdc_seq_t SEQ_RESET = MDC_SEQ_CONSUMER;
endpackage

// file: mdc_tick_gen.sv
/*
  mdc_tick_gen: one-second tick pulse and a flash phase toggling each tick.
  assumes CYCLES is the clock count of one second.
*/
`timescale 1ns/1ps
module mdc_tick_gen #(
  parameter int CYCLES = mdc_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick_q,
  output logic blink_q
);
  localparam int W = $clog2(CYCLES);
  logic [W-1:0] div_q;

  if (CYCLES < 2) begin : g_bad
    $error("tick divider needs at least two cycles");
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == W'(CYCLES - 1));
      div_q <= (div_q == W'(CYCLES - 1)) ? '0 : div_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      blink_q <= 1'b0;
    end else if (tick_q) begin
      blink_q <= ~blink_q;
    end
  end
endmodule

// file: mdc_sec_timer.sv
/*
  mdc_sec_timer: counts seconds since the last restart, flags when LIMIT is reached.
  assumes tick is a one-cycle pulse once per second.
*/
`timescale 1ns/1ps
module mdc_sec_timer #(
  parameter int LIMIT = mdc_pkg::BACKLIGHT_S
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic restart,
  output logic expired_q
);
  localparam int W = $clog2(LIMIT + 1);
  logic [W-1:0] count_q;

  if (LIMIT < 1) begin : g_bad
    $error("timer limit must be at least one second");
  end

  always_ff @(posedge clk) begin
    if (rst || restart) begin
      count_q <= '0;
      expired_q <= 1'b0;
    end else if (tick && !expired_q) begin
      count_q <= count_q + 1'b1;
      expired_q <= (count_q == W'(LIMIT - 1));
    end
  end
endmodule

// file: mdc_display_ctrl.sv
/*
  mdc_display_ctrl: front-panel display and key controller of a heat/cooling meter.
  assumes keys are debounced and all inputs are synchronous to clk.
*/
`timescale 1ns/1ps
module mdc_display_ctrl #(
  parameter int TICK_CYCLES = mdc_pkg::TICK_CYCLES,
  parameter int READINGS = mdc_pkg::READINGS_DEF,
  parameter int SUB_READINGS = mdc_pkg::SUBS_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic key_primary,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic light_cfg,
  input wire logic [1:0] mode_code,
  input wire logic wide_cfg,
  input wire logic transport_state,
  input wire logic country_blocks_cfg,
  input wire logic install_seal_broken,
  input wire logic verif_seal_broken,
  input wire logic top_base_sep,
  input wire logic cfg_log_full,
  input wire logic optical_disabled,
  input wire logic core_active,
  input wire logic [15:0] flow_rate,
  input wire logic [15:0] nominal_flow,
  input wire logic flow_pulse,
  input wire logic [2:0] sensor_err,
  input wire logic cooling_active,
  input wire logic store_ok,
  input wire logic info_active,
  output logic display_on_q,
  output logic backlight_q,
  output logic [3:0] digit_count_q,
  output mdc_pkg::mdc_ui_t ui_q,
  output mdc_pkg::mdc_seq_t seq_q,
  output mdc_pkg::mdc_seq_t choose_seq_q,
  output logic show_index_q,
  output logic [$clog2(READINGS)-1:0] reading_idx_q,
  output logic [$clog2(SUB_READINGS)-1:0] sub_idx_q,
  output logic dash_inlet_q,
  output logic dash_outlet_q,
  output logic dash_third_q,
  output logic dash_delta_q,
  output logic info_code_q,
  output logic [10:0] halt_q,
  output logic halt_tariff_q,
  output logic vol_count_en_q,
  output logic flow_zero_q,
  output logic delta_neg_q,
  output logic ok_sym_q,
  output logic info_sym_q,
  output logic heart_seg_q,
  output logic cfg_seg_q,
  output logic opt_seg_q
);
  localparam int RW = $clog2(READINGS);
  localparam int SW = $clog2(SUB_READINGS);

  if (READINGS < 2 || SUB_READINGS < 2) begin : g_bad
    $error("need at least two readings and two sub readings");
  end

  ////////////////////////////////////////////////////////////////////////
  // tick, keys and timers

  logic tick;
  logic blink;
  logic [2:0] keys_prev_q;
  logic prim_p;
  logic up_p;
  logic down_p;
  logic prim_rel;
  logic any_press;
  logic bl_exp;
  logic disp_exp;
  logic hold_exp;
  logic flow_exp;
  logic sep_exp;
  logic sep_seen_q;
  logic sep_window;
  logic hold_done_q;
  logic hold_fire;
  logic short_rel;
  logic display_on_d;

  mdc_tick_gen #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .tick_q(tick),
    .blink_q(blink)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      keys_prev_q <= 3'h0;
    end else begin
      keys_prev_q <= {key_down, key_up, key_primary};
    end
  end

  assign prim_p = key_primary & ~keys_prev_q[0];
  assign up_p = key_up & ~keys_prev_q[1];
  assign down_p = key_down & ~keys_prev_q[2];
  assign prim_rel = keys_prev_q[0] & ~key_primary;
  assign any_press = prim_p | up_p | down_p;

  // key presses restart the display timers
  mdc_sec_timer #(
    .LIMIT(mdc_pkg::BACKLIGHT_S)
  ) u_bl_timer (
    .clk(clk),
    .rst(rst),
    .tick(tick), // RULE23
    .restart(any_press), // RULE23
    .expired_q(bl_exp)
  );

  mdc_sec_timer #(
    .LIMIT(mdc_pkg::DISPLAY_OFF_S)
  ) u_disp_timer (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .restart(any_press), // RULE23
    .expired_q(disp_exp)
  );

  mdc_sec_timer #(
    .LIMIT(mdc_pkg::PRIMARY_HOLD_S)
  ) u_hold_timer (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .restart(~key_primary),
    .expired_q(hold_exp)
  );

  mdc_sec_timer #(
    .LIMIT(mdc_pkg::FLOW_TIMEOUT_S)
  ) u_flow_timer (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .restart(flow_pulse),
    .expired_q(flow_exp)
  );

  mdc_sec_timer #(
    .LIMIT(mdc_pkg::SEP_WINDOW_S)
  ) u_sep_timer (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .restart(top_base_sep),
    .expired_q(sep_exp)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      sep_seen_q <= 1'b0;
    end else if (top_base_sep) begin
      sep_seen_q <= 1'b1;
    end
  end

  assign sep_window = sep_seen_q & ~sep_exp;

  // one chooser entry per hold; the release after it is not a short press
  assign hold_fire = key_primary & hold_exp & ~hold_done_q; // RULE10
  assign short_rel = prim_rel & ~hold_done_q;

  always_ff @(posedge clk) begin
    if (rst || !key_primary) begin
      hold_done_q <= 1'b0;
    end else if (hold_fire) begin
      hold_done_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // display and backlight

  assign display_on_d = any_press | ~disp_exp | (mode_code != mdc_pkg::MODE_TIMED); // RULE2

  always_ff @(posedge clk) begin
    if (rst) begin
      display_on_q <= 1'b1;
      backlight_q <= 1'b0;
    end else begin
      display_on_q <= display_on_d;
      backlight_q <= display_on_d & ((mode_code == mdc_pkg::MODE_LIGHT_ON) // RULE3
                     | (light_cfg & (any_press | ~bl_exp))); // RULE1
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      digit_count_q <= mdc_pkg::DIGITS_SHORT;
    end else begin
      digit_count_q <= wide_cfg ? mdc_pkg::DIGITS_LONG : mdc_pkg::DIGITS_SHORT; // RULE4
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequence access and chooser

  logic first_flow_q;
  logic cfg_access;
  logic [3:0] avail;
  logic act;
  mdc_pkg::mdc_seq_t seq_d;
  mdc_pkg::mdc_seq_t pick;

  always_ff @(posedge clk) begin
    if (rst) begin
      first_flow_q <= 1'b0;
    end else if ({8'h00, flow_rate} * mdc_pkg::PCT_SCALE
                 >= {8'h00, nominal_flow} * mdc_pkg::FIRST_FLOW_PCT) begin
      first_flow_q <= 1'b1; // RULE7
    end
  end

  assign cfg_access = ~cfg_log_full & (install_seal_broken | sep_window // RULE7
                      | (transport_state & ~country_blocks_cfg & ~first_flow_q)); // RULE9
  assign avail = {verif_seal_broken, cfg_access, 2'h3}; // RULE6 RULE8

  function automatic mdc_pkg::mdc_seq_t step_seq(input mdc_pkg::mdc_seq_t cur,
                                                 input logic up, input logic [3:0] ok);
    logic [1:0] s;
    logic hit;
    mdc_pkg::mdc_seq_t r;
    s = cur;
    hit = 1'b0;
    r = cur;
    for (int i = 0; i < 4; i++) begin
      s = up ? s + 2'h1 : s - 2'h1;
      if (ok[s] && !hit) begin
        r = mdc_pkg::mdc_seq_t'(s);
        hit = 1'b1;
      end
    end
    step_seq = r;
  endfunction

  // an arrow press on a dark display only wakes it; the release of a primary press still acts
  assign act = any_press & display_on_q; // RULE5

  always_comb begin
    pick = choose_seq_q;
    if (ui_q == mdc_pkg::MDC_UI_CHOOSE && short_rel && display_on_q) begin
      pick = choose_seq_q;
    end
    seq_d = seq_q;
    if (ui_q == mdc_pkg::MDC_UI_CHOOSE && short_rel && display_on_q) begin
      seq_d = pick;
    end
    if (!avail[seq_d]) begin
      seq_d = mdc_pkg::MDC_SEQ_CONSUMER; // RULE8
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ui_q <= mdc_pkg::MDC_UI_RUN;
    end else begin
      unique case (ui_q)
        mdc_pkg::MDC_UI_RUN: begin
          if (hold_fire && display_on_q) begin
            ui_q <= mdc_pkg::MDC_UI_CHOOSE; // RULE10
          end
        end
        mdc_pkg::MDC_UI_CHOOSE: begin
          if (short_rel && display_on_q) begin
            ui_q <= mdc_pkg::MDC_UI_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      choose_seq_q <= mdc_pkg::SEQ_RESET;
    end else if (ui_q == mdc_pkg::MDC_UI_RUN) begin
      choose_seq_q <= seq_q;
    end else if (act && up_p) begin
      choose_seq_q <= step_seq(choose_seq_q, 1'b1, avail); // RULE10
    end else if (act && down_p) begin
      choose_seq_q <= step_seq(choose_seq_q, 1'b0, avail);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      seq_q <= mdc_pkg::SEQ_RESET;
      show_index_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      show_index_q <= (seq_d != mdc_pkg::MDC_SEQ_CONSUMER); // RULE11
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reading position within a sequence

  logic run_act;
  assign run_act = act & (ui_q == mdc_pkg::MDC_UI_RUN);

  always_ff @(posedge clk) begin
    if (rst || seq_d != seq_q) begin
      reading_idx_q <= '0;
      sub_idx_q <= '0;
    end else if (run_act && up_p) begin
      reading_idx_q <= (reading_idx_q == RW'(READINGS - 1)) ? '0 : reading_idx_q + 1'b1; // RULE22
      sub_idx_q <= '0;
    end else if (run_act && down_p) begin
      reading_idx_q <= (reading_idx_q == '0) ? RW'(READINGS - 1) : reading_idx_q - 1'b1; // RULE22
      sub_idx_q <= '0;
    end else if (short_rel && display_on_q && ui_q == mdc_pkg::MDC_UI_RUN
                 && seq_q == mdc_pkg::MDC_SEQ_SERVICE) begin
      sub_idx_q <= (sub_idx_q == SW'(SUB_READINGS - 1)) ? '0 : sub_idx_q + 1'b1; // RULE22
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sensor faults, flow and sign

  always_ff @(posedge clk) begin
    if (rst) begin
      dash_inlet_q <= 1'b0;
      dash_outlet_q <= 1'b0;
      dash_third_q <= 1'b0;
      dash_delta_q <= 1'b0;
      info_code_q <= 1'b0;
    end else begin
      dash_inlet_q <= sensor_err[0]; // RULE12
      dash_outlet_q <= sensor_err[1];
      dash_third_q <= sensor_err[2];
      dash_delta_q <= sensor_err[0] | sensor_err[1]; // RULE14
      info_code_q <= |sensor_err; // RULE12
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      halt_q <= 11'h000;
      halt_tariff_q <= 1'b0;
      vol_count_en_q <= 1'b1;
    end else begin
      halt_q <= ({mdc_pkg::ACC_COUNT{sensor_err[0]}} & mdc_pkg::HALT_INLET) // RULE13
              | ({mdc_pkg::ACC_COUNT{sensor_err[1]}} & mdc_pkg::HALT_OUTLET)
              | ({mdc_pkg::ACC_COUNT{sensor_err[2]}} & mdc_pkg::HALT_THIRD);
      halt_tariff_q <= sensor_err[0] | sensor_err[1]; // RULE13
      vol_count_en_q <= 1'b1; // RULE14
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flow_zero_q <= 1'b0;
      delta_neg_q <= 1'b0;
    end else begin
      flow_zero_q <= flow_exp; // RULE15
      // energy totals carry no sign at all
      delta_neg_q <= cooling_active; // RULE19
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // symbols and status segments

  always_ff @(posedge clk) begin
    if (rst) begin
      ok_sym_q <= 1'b0;
    end else if (store_ok) begin
      ok_sym_q <= 1'b1; // RULE20
    end else if (any_press) begin
      ok_sym_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      info_sym_q <= 1'b0;
      heart_seg_q <= 1'b0;
      cfg_seg_q <= 1'b0;
      opt_seg_q <= 1'b0;
    end else begin
      info_sym_q <= (info_active | (|sensor_err)) & blink; // RULE21
      heart_seg_q <= core_active & display_on_q & blink; // RULE16
      cfg_seg_q <= cfg_log_full | (cfg_access & blink); // RULE17
      opt_seg_q <= sep_window ? blink : optical_disabled; // RULE18
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_wake;
    any_press && !display_on_q;
  endsequence

  sequence s_long_hold;
    hold_fire && display_on_q && ui_q == mdc_pkg::MDC_UI_RUN;
  endsequence

  wake_only_a: assert property (s_wake |=> display_on_q && $stable(reading_idx_q) && $stable(seq_q)) // RULE5
    else $error("a wake press changed the reading");
  chooser_entry_a: assert property (s_long_hold |=> ui_q == mdc_pkg::MDC_UI_CHOOSE) // RULE10
    else $error("long primary hold did not open the chooser");
  disp_keep_a: assert property (mode_code != mdc_pkg::MODE_TIMED |=> display_on_q) // RULE2
    else $error("display blanked in a permanent mode");
  light_keep_a: assert property (mode_code == mdc_pkg::MODE_LIGHT_ON |=> backlight_q) // RULE3
    else $error("backlight off in permanent light mode");
  reverify_gate_a: assert property (seq_q == mdc_pkg::MDC_SEQ_REVERIFY |-> $past(verif_seal_broken)) // RULE8
    else $error("reverification sequence with seal intact");
  cfg_block_a: assert property (first_flow_q && !install_seal_broken && !sep_window
                                |=> seq_q != mdc_pkg::MDC_SEQ_CONFIG) // RULE7
    else $error("configuration reachable after first flow");
  index_show_a: assert property (show_index_q == (seq_q != mdc_pkg::MDC_SEQ_CONSUMER)) // RULE11
    else $error("index display disagrees with sequence");
  delta_dash_a: assert property ((sensor_err[0] || sensor_err[1]) |=> dash_delta_q && vol_count_en_q) // RULE14
    else $error("difference not dashed or volume halted");
  halt_inlet_a: assert property (sensor_err[0] |=> (halt_q & mdc_pkg::HALT_INLET) == mdc_pkg::HALT_INLET
                                 && halt_tariff_q) // RULE13
    else $error("inlet fault left an accumulator running");
  flow_zero_a: assert property (flow_pulse |=> ##1 !flow_zero_q) // RULE15
    else $error("flow forced to zero despite a pulse");
  heart_beat_a: assert property (!(core_active && display_on_q) |=> !heart_seg_q) // RULE16
    else $error("heartbeat lit while core or display idle");
  ok_symbol_a: assert property (store_ok |=> ok_sym_q) // RULE20
    else $error("store not acknowledged by the OK symbol");
  digit_count_a: assert property (wide_cfg |=> digit_count_q == mdc_pkg::DIGITS_LONG) // RULE4
    else $error("wide configuration not shown on eight digits");
endmodule

// file: mdc_keys.sv
/*
  mdc_keys: operator at the front keys, pressing, tapping and holding.
  assumes the bench calls its tasks; keys change 2 ns after a rising edge.
*/
`timescale 1ns/1ps
module mdc_keys (
  input wire logic clk,
  output logic key_primary,
  output logic key_up,
  output logic key_down
);
  logic [2:0] k = 3'h0;
  assign {key_down, key_up, key_primary} = k;
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // short press, then a low gap before any next press
  task automatic tap(input int i);
    k[i] = 1'b1;
    wait_cyc(2);
    k[i] = 1'b0;
    wait_cyc(3);
  endtask
  // primary held into the chooser, released, arrows stepped, short press selects
  task automatic choose(input int steps, input int cycles);
    k[0] = 1'b1;
    wait_cyc(cycles);
    k[0] = 1'b0;
    wait_cyc(3);
    repeat (steps) tap(1);
    tap(0);
  endtask
endmodule

// file: mdc_display_ctrl_bench.sv
/*
  mdc_display_ctrl_bench: self-checking bench of the display controller.
  assumes a 4-cycle second, 4 readings and 2 sub-readings.
*/
`timescale 1ns/1ps
module mdc_display_ctrl_bench;
  localparam int TC = 4;
  logic clk, rst, light_cfg, wide_cfg, transport_state, country_blocks_cfg;
  logic install_seal_broken, verif_seal_broken, top_base_sep, cfg_log_full;
  logic optical_disabled, core_active, flow_pulse, cooling_active, store_ok, info_active;
  logic [1:0] mode_code;
  logic [15:0] flow_rate, nominal_flow;
  logic [2:0] sensor_err;
  wire key_primary, key_up, key_down;
  wire display_on_q, backlight_q, show_index_q, dash_inlet_q, dash_outlet_q, dash_third_q;
  wire dash_delta_q, info_code_q, halt_tariff_q, vol_count_en_q, flow_zero_q, delta_neg_q;
  wire ok_sym_q, info_sym_q, heart_seg_q, cfg_seg_q, opt_seg_q;
  wire [3:0] digit_count_q;
  wire [10:0] halt_q;
  wire [1:0] reading_idx_q;
  wire [0:0] sub_idx_q;
  mdc_pkg::mdc_ui_t ui_q;
  mdc_pkg::mdc_seq_t seq_q, choose_seq_q;
  wire [3:0] segs = {heart_seg_q, cfg_seg_q, info_sym_q, opt_seg_q};
  int fails = 0;
  int n_tests = 0;

  mdc_keys KEYS (.clk(clk), .key_primary(key_primary), .key_up(key_up), .key_down(key_down));
  mdc_display_ctrl #(.TICK_CYCLES(TC), .READINGS(4), .SUB_READINGS(2)) DUT (
    .clk(clk), .rst(rst), .key_primary(key_primary), .key_up(key_up), .key_down(key_down),
    .light_cfg(light_cfg), .mode_code(mode_code), .wide_cfg(wide_cfg),
    .transport_state(transport_state), .country_blocks_cfg(country_blocks_cfg),
    .install_seal_broken(install_seal_broken), .verif_seal_broken(verif_seal_broken),
    .top_base_sep(top_base_sep), .cfg_log_full(cfg_log_full), .optical_disabled(optical_disabled),
    .core_active(core_active), .flow_rate(flow_rate), .nominal_flow(nominal_flow),
    .flow_pulse(flow_pulse), .sensor_err(sensor_err), .cooling_active(cooling_active),
    .store_ok(store_ok), .info_active(info_active), .display_on_q(display_on_q),
    .backlight_q(backlight_q), .digit_count_q(digit_count_q), .ui_q(ui_q), .seq_q(seq_q),
    .choose_seq_q(choose_seq_q), .show_index_q(show_index_q), .reading_idx_q(reading_idx_q),
    .sub_idx_q(sub_idx_q), .dash_inlet_q(dash_inlet_q), .dash_outlet_q(dash_outlet_q),
    .dash_third_q(dash_third_q), .dash_delta_q(dash_delta_q), .info_code_q(info_code_q),
    .halt_q(halt_q), .halt_tariff_q(halt_tariff_q), .vol_count_en_q(vol_count_en_q),
    .flow_zero_q(flow_zero_q), .delta_neg_q(delta_neg_q), .ok_sym_q(ok_sym_q),
    .info_sym_q(info_sym_q), .heart_seg_q(heart_seg_q), .cfg_seg_q(cfg_seg_q), .opt_seg_q(opt_seg_q));

  ////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // segments seen high / seen low over four seconds
  task automatic win(input logic [3:0] e1, input logic [3:0] e0);
    logic [3:0] a1, a0;
    a1 = 4'h0;
    a0 = 4'h0;
    repeat (4 * TC) begin
      cyc(1);
      a1 = a1 | segs;
      a0 = a0 | ~segs;
    end
    chk("segs high", {12'h0, e1}, {12'h0, a1});
    chk("segs low", {12'h0, e0}, {12'h0, a0});
  endtask
  function automatic logic [10:0] halt_exp(input logic [2:0] e);
    halt_exp = (e[0] ? mdc_pkg::HALT_INLET : 11'h0) | (e[1] ? mdc_pkg::HALT_OUTLET : 11'h0)
      | (e[2] ? mdc_pkg::HALT_THIRD : 11'h0);
  endfunction
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    give_verdict();
  end
  initial begin
    {rst, light_cfg, transport_state, core_active} = 4'hf;
    {wide_cfg, country_blocks_cfg, install_seal_broken, verif_seal_broken} = 4'h0;
    {top_base_sep, cfg_log_full, optical_disabled, flow_pulse} = 4'h0;
    {cooling_active, store_ok, info_active} = 3'h0;
    mode_code = mdc_pkg::MODE_TIMED;
    flow_rate = 16'h0000;
    nominal_flow = 16'h0064;
    sensor_err = 3'h0;
    repeat (2) @(posedge clk);
    #2 rst = 1'b0;
    cyc(1);
    chk("reset", 16'h00c2, {8'h0, display_on_q, backlight_q, ui_q, seq_q, show_index_q, vol_count_en_q,
      ok_sym_q});
    chk("digits", 16'h0007, {12'h0, digit_count_q});
    wide_cfg = 1'b1;
    cyc(2);
    chk("digits", 16'h0008, {12'h0, digit_count_q});
    win(4'hc, 4'hf);
    flow_rate = 16'h0001;
    optical_disabled = 1'b1;
    win(4'h9, 4'he);
    cfg_log_full = 1'b1;
    top_base_sep = 1'b1;
    cyc(1);
    top_base_sep = 1'b0;
    win(4'hd, 4'hb);
    for (int e = 1; e < 8; e++) begin
      sensor_err = 3'(e);
      cyc(2);
      chk("halt", {5'h0, halt_exp(3'(e))}, {5'h0, halt_q});
      chk("dash", 16'(e), {13'h0, dash_third_q, dash_outlet_q, dash_inlet_q});
      chk("flags", {12'h0, e[0] | e[1], e[0] | e[1], 2'h3},
        {12'h0, dash_delta_q, halt_tariff_q, info_code_q, vol_count_en_q});
    end
    win(4'hf, 4'hb);
    sensor_err = 3'h0;
    {core_active, info_active} = 2'h1;
    win(4'h7, 4'hb);
    core_active = 1'b1;
    info_active = 1'b0;
    cooling_active = 1'b1;
    store_ok = 1'b1;
    cyc(1);
    store_ok = 1'b0;
    cyc(2);
    chk("sign ok", 16'h0003, {14'h0, delta_neg_q, ok_sym_q});
    KEYS.tap(1);
    chk("ok idx", 16'h0001, {13'h0, ok_sym_q, reading_idx_q});
    KEYS.choose(1, 6 * TC);
    chk("service", 16'h0019, {9'h0, ui_q, seq_q, show_index_q, sub_idx_q, choose_seq_q});
    KEYS.tap(0);
    chk("sub", 16'h0001, {15'h0, sub_idx_q});
    KEYS.tap(1);
    chk("step", 16'h0002, {13'h0, reading_idx_q, sub_idx_q});
    verif_seal_broken = 1'b1;
    KEYS.choose(1, 6 * TC);
    chk("reverify", 16'h0007, {13'h0, seq_q, show_index_q});
    verif_seal_broken = 1'b0;
    cyc(2);
    chk("consumer", 16'h0000, {13'h0, seq_q, show_index_q});
    KEYS.tap(2);
    chk("wrap", 16'h0007, {13'h0, backlight_q, reading_idx_q});
    cyc(12 * TC);
    chk("light", 16'h0001, {15'h0, backlight_q});
    cyc(4 * TC);
    chk("light", 16'h0000, {15'h0, backlight_q});
    mode_code = mdc_pkg::MODE_LIGHT_ON;
    cyc(250 * TC);
    chk("lit", 16'h0003, {14'h0, backlight_q, display_on_q});
    mode_code = mdc_pkg::MODE_TIMED;
    cyc(242 * TC);
    chk("blank", 16'h0000, {15'h0, display_on_q});
    KEYS.tap(1);
    chk("wake", 16'h0007, {13'h0, display_on_q, reading_idx_q});
    chk("flow", 16'h0000, {15'h0, flow_zero_q});
    cyc(3100 * TC);
    chk("flow", 16'h0001, {15'h0, flow_zero_q});
    flow_pulse = 1'b1;
    cyc(1);
    flow_pulse = 1'b0;
    cyc(2);
    chk("flow", 16'h0000, {15'h0, flow_zero_q});
    give_verdict();
  end
endmodule
